//--- ssprg_consts.svh
// constants for the synthesizer serial programming register bank
`ifndef SSPRG_CONSTS_SVH
`define SSPRG_CONSTS_SVH

// ************************************************************
// word geometry
// ************************************************************
`define SSPRG_WORD_W        24
`define SSPRG_ADDR_LSB      0
`define SSPRG_ADDR_MSB      1
`define SSPRG_SUB_LSB       20
`define SSPRG_SUB_MSB       22
// bit set in word four's fixed pattern but clear in word five's
`define SSPRG_W4_MARK       5

// ************************************************************
// frequency control word fields
// ************************************************************
`define SSPRG_FC_TXRX       23
`define SSPRG_FC_PD         22
`define SSPRG_FC_FAST       21
`define SSPRG_FC_BAND       19
`define SSPRG_FC_PCNT_MSB   18
`define SSPRG_FC_PCNT_LSB   15
`define SSPRG_FC_SWAL_MSB   14
`define SSPRG_FC_SWAL_LSB   12
`define SSPRG_FC_FRAC_MSB   11
`define SSPRG_FC_FRAC_LSB   2

// ************************************************************
// configuration word fields
// ************************************************************
`define SSPRG_CF_DEFSEL     23
`define SSPRG_CF_LOCKEN     6
`define SSPRG_CF_OBUF_MSB   5
`define SSPRG_CF_OBUF_LSB   4
`define SSPRG_CF_REF_MSB    3
`define SSPRG_CF_REF_LSB    2

// ************************************************************
// built-in word values used when default selection is on, and the reset word
// ************************************************************
`define SSPRG_DEF_FREQ      24'h000000
`define SSPRG_DEF_CONF      24'h128101
`define SSPRG_DEF_WORD2     24'hc87806
`define SSPRG_RST_WORD      24'h000000

// ************************************************************
// divider multiplier shifts per band and denominators
// ************************************************************
`define SSPRG_MULT_UPPER    3'd3
`define SSPRG_MULT_LOWER    3'd2
`define SSPRG_FD_504        10'd504
`define SSPRG_FD_576        10'd576
`define SSPRG_FD_520        10'd520
`define SSPRG_FD_630        10'd630
`define SSPRG_FD_720        10'd720
`define SSPRG_FD_650        10'd650
`define SSPRG_FD_567        10'd567
`define SSPRG_FD_648        10'd648
`define SSPRG_FD_585        10'd585

`endif

//--- ssprg_pkg.sv
// types for the synthesizer serial programming register bank
package ssprg_pkg;
	// register selector, four address bit patterns expanded to six
	typedef enum logic [2:0]
	{
		SSPRG_SEL_FREQ,
		SSPRG_SEL_CONF,
		SSPRG_SEL_W2,
		SSPRG_SEL_W3,
		SSPRG_SEL_W4,
		SSPRG_SEL_W5
	} ssprg_sel_t;

	// reference frequency choice
	typedef enum logic [1:0]
	{
		SSPRG_REF_12M6,
		SSPRG_REF_14M4,
		SSPRG_REF_25M2,
		SSPRG_REF_26M0
	} ssprg_ref_t;

	typedef logic [23:0] ssprg_word_t;
endpackage : ssprg_pkg

//--- ssprg_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ssprg_pin_sync
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pinIn,
	output logic      level
);
	logic [2:0] stage_q;   // stage 0 feeds only stage 1
	logic [2:0] stage_d;
	logic       level_q;
	logic       level_d;

	// ************************************************************
	// next values
	// ************************************************************
	always_comb
	begin
		stage_d = {stage_q[1:0], pinIn};
		level_d = level_q;
		// change counts only once stages one and two agree
		if (stage_q[1] == stage_q[2])
		begin
			level_d = stage_q[2];
		end
	end

	// registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stage_q <= 3'h0;
			level_q <= 1'b0;
		end
		else
		begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign level = level_q;
endmodule : ssprg_pin_sync

//--- ssprg_regs.sv
// serial programming front end: shift register and six control words
`timescale 1ns/1ps
`include "ssprg_consts.svh"

// Overview of operation
// RL1: 24-bit shift register, first bit is MSB
// RL2: shift one bit per serial clock rise
// RL3: latch rise copies word to addressed register
// RL4: host loads word two, config, then frequency
// RL5: later retune writes only the frequency word
// RL6: address 00 selects frequency control word
// RL7: bit 23 selects receive or transmit
// RL8: bit 22 powers synthesizer down
// RL9: bit 21 selects high-speed locking
// RL10: bit 19 picks upper or lower oscillator
// RL11: bits 18..15 programmable count
// RL12: bits 14..12 swallow count
// RL13: bits 11..2 fractional numerator
// RL14: divide ratio uses multiplier eight or four
// RL15: address 01 selects configuration word
// RL16: default select uses built-in first three words
// RL17: reference choice sets divider one or two
// RL18: lock enable gates the lock output
// RL19: host writes fixed patterns and zero bits
// RL20: registers change only at latch rise
module ssprg_regs
(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic                serialClk,
	input  wire logic                serialData,
	input  wire logic                latchStrobe,
	input  wire logic                pllLocked,
	output logic                     txSelect,
	output logic                     synthPowerdown,
	output logic                     fastLockSelect,
	output logic                     bandChoice,
	output logic [3:0]               programmableCount,
	output logic [2:0]               swallowCount,
	output logic [9:0]               fractionNumerator,
	output logic [9:0]               fractionDenominator,
	output logic [7:0]               integerDivide,
	output logic                     refDivideTwo,
	output ssprg_pkg::ssprg_ref_t    refclkChoice,
	output logic [1:0]               outBufferLevel,
	output logic                     lockOut,
	output ssprg_pkg::ssprg_word_t   setupWord2,
	output ssprg_pkg::ssprg_word_t   setupWord3,
	output ssprg_pkg::ssprg_word_t   setupWord4,
	output ssprg_pkg::ssprg_word_t   setupWord5
);
	import ssprg_pkg::*;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic sClkLvl;     // filtered serial clock
	logic sDataLvl;    // filtered serial data
	logic latchLvl;    // filtered latch strobe
	logic lockLvl;     // filtered lock status

	ssprg_pin_sync uSyncClk
	(
		.clk   (clk),
		.rst   (rst),
		.pinIn (serialClk),
		.level (sClkLvl)
	);
	ssprg_pin_sync uSyncData
	(
		.clk   (clk),
		.rst   (rst),
		.pinIn (serialData),
		.level (sDataLvl)
	);
	ssprg_pin_sync uSyncLatch
	(
		.clk   (clk),
		.rst   (rst),
		.pinIn (latchStrobe),
		.level (latchLvl)
	);
	ssprg_pin_sync uSyncLock
	(
		.clk   (clk),
		.rst   (rst),
		.pinIn (pllLocked),
		.level (lockLvl)
	);

	// ************************************************************
	// decode helpers
	// ************************************************************
	// address bits plus the fixed pattern split the word into six targets;
	// the two address bits only reach four codes, so words two to five share
	// address 1x; word two is picked by bits 22..20 of its fixed pattern, words three to five need address 11 and bits 23 and 5
	function automatic logic [2:0] word_target(input ssprg_word_t w);
		logic [1:0] a;
		a = w[`SSPRG_ADDR_MSB:`SSPRG_ADDR_LSB];
		word_target = 3'h7;
		if (a == 2'h0)
		begin
			word_target = 3'h0;
		end
		else if (a == 2'h1)
		begin
			word_target = 3'h1;
		end
		else if (w[`SSPRG_SUB_MSB:`SSPRG_SUB_LSB] == 3'h4)
		begin
			word_target = 3'h2;
		end
		else if (a == 2'h3 && w[`SSPRG_WORD_W-1])
		begin
			word_target = 3'h3;
		end
		else if (a == 2'h3 && w[`SSPRG_W4_MARK])
		begin
			word_target = 3'h4;
		end
		else if (a == 2'h3)
		begin
			word_target = 3'h5;
		end
	endfunction : word_target

	// denominator from transmit, band and reference choice
	function automatic logic [9:0] denom(input logic tx, input logic bnd, input logic [1:0] rf);
		denom = `SSPRG_FD_504;
		if (!tx)
		begin
			denom = (rf == 2'h1) ? `SSPRG_FD_576 : (rf == 2'h3) ? `SSPRG_FD_520 : `SSPRG_FD_504;
		end
		else if (!bnd)
		begin
			denom = (rf == 2'h1) ? `SSPRG_FD_720 : (rf == 2'h3) ? `SSPRG_FD_650 : `SSPRG_FD_630;
		end
		else
		begin
			denom = (rf == 2'h1) ? `SSPRG_FD_648 : (rf == 2'h3) ? `SSPRG_FD_585 : `SSPRG_FD_567;
		end
	endfunction : denom

	// ************************************************************
	// shift and latch state
	// ************************************************************
	logic        sClkPrev_q;   // edge finder on filtered serial clock
	logic        sClkPrev_d;
	logic        latchPrev_q;  // edge finder on filtered latch
	logic        latchPrev_d;
	ssprg_word_t shift_q;      // incoming word
	ssprg_word_t shift_d;
	ssprg_word_t word_q [6];   // six control registers, by index
	ssprg_word_t word_d [6];
	logic [2:0]  tgt;          // decoded target of the shifted word

	always_comb
	begin
		tgt         = word_target(shift_q);
		sClkPrev_d  = sClkLvl;
		latchPrev_d = latchLvl;
		shift_d     = shift_q;
		// RL2: shift on rise
		// RL1: msb first in
		if (sClkLvl && !sClkPrev_q)
		begin
			shift_d = {shift_q[`SSPRG_WORD_W-2:0], sDataLvl};
		end
		for (int i = 0; i < 6; i++)
		begin
			word_d[i] = word_q[i];
		end
		// RL20: latch edge only
		// RL3: copy on rise
		// RL6: RL15: address decode
		if (latchLvl && !latchPrev_q && tgt != 3'h7)
		begin
			word_d[tgt] = shift_q;
		end
	end

	// registers; reset leaves the words cleared since none is documented
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sClkPrev_q  <= 1'b0;
			latchPrev_q <= 1'b0;
			shift_q     <= `SSPRG_RST_WORD;
			for (int i = 0; i < 6; i++)
			begin
				word_q[i] <= `SSPRG_RST_WORD;
			end
		end
		else
		begin
			sClkPrev_q  <= sClkPrev_d;
			latchPrev_q <= latchPrev_d;
			shift_q     <= shift_d;
			for (int i = 0; i < 6; i++)
			begin
				word_q[i] <= word_d[i];
			end
		end
	end

	// ************************************************************
	// effective words and field outputs
	// ************************************************************
	ssprg_word_t effFreq;   // frequency word in use
	ssprg_word_t effConf;   // configuration word in use
	ssprg_word_t effW2;     // word two in use
	logic [7:0]  intDiv;    // integer part of divide ratio
	logic        lock_d;    // gated lock indication
	logic        lock_q;
	logic [58:0] fld_d;     // packed field outputs
	logic [58:0] fld_q;
	ssprg_word_t w2_q;
	ssprg_word_t w3_q;
	ssprg_word_t w4_q;
	ssprg_word_t w5_q;

	always_comb
	begin
		// RL16: built-in defaults
		if (word_q[1][`SSPRG_CF_DEFSEL])
		begin
			effFreq = `SSPRG_DEF_FREQ;
			effConf = `SSPRG_DEF_CONF;
			effW2   = `SSPRG_DEF_WORD2;
		end
		else
		begin
			effFreq = word_q[0];
			effConf = word_q[1];
			effW2   = word_q[2];
		end
		// RL14: multiplier by band
		intDiv = effFreq[`SSPRG_FC_BAND]
			? (8'(effFreq[`SSPRG_FC_PCNT_MSB:`SSPRG_FC_PCNT_LSB]) << `SSPRG_MULT_UPPER)
			: (8'(effFreq[`SSPRG_FC_PCNT_MSB:`SSPRG_FC_PCNT_LSB]) << `SSPRG_MULT_LOWER);
		intDiv = intDiv + 8'(effFreq[`SSPRG_FC_SWAL_MSB:`SSPRG_FC_SWAL_LSB]);
		// RL18: lock gating, also low in power down
		lock_d = effConf[`SSPRG_CF_LOCKEN] && !effFreq[`SSPRG_FC_PD] && lockLvl;
		// RL7: RL8: RL9: RL10: control bits
		// RL11: RL12: RL13: counter fields
		// RL17: reference divide
		fld_d = {
			effFreq[`SSPRG_FC_TXRX],
			effFreq[`SSPRG_FC_PD],
			effFreq[`SSPRG_FC_FAST],
			effFreq[`SSPRG_FC_BAND],
			effFreq[`SSPRG_FC_PCNT_MSB:`SSPRG_FC_PCNT_LSB],
			effFreq[`SSPRG_FC_SWAL_MSB:`SSPRG_FC_SWAL_LSB],
			effFreq[`SSPRG_FC_FRAC_MSB:`SSPRG_FC_FRAC_LSB],
			denom(effFreq[`SSPRG_FC_TXRX], effFreq[`SSPRG_FC_BAND],
				effConf[`SSPRG_CF_REF_MSB:`SSPRG_CF_REF_LSB]),
			intDiv,
			effConf[`SSPRG_CF_REF_MSB],
			effConf[`SSPRG_CF_REF_MSB:`SSPRG_CF_REF_LSB],
			effConf[`SSPRG_CF_OBUF_MSB:`SSPRG_CF_OBUF_LSB],
			effConf[`SSPRG_CF_LOCKEN],
			14'h0000
		};
	end

	// output registers keep every output straight from a flop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fld_q  <= '0;
			lock_q <= 1'b0;
			w2_q   <= `SSPRG_RST_WORD;
			w3_q   <= `SSPRG_RST_WORD;
			w4_q   <= `SSPRG_RST_WORD;
			w5_q   <= `SSPRG_RST_WORD;
		end
		else
		begin
			fld_q  <= fld_d;
			lock_q <= lock_d;
			w2_q   <= effW2;
			w3_q   <= word_q[3];
			w4_q   <= word_q[4];
			w5_q   <= word_q[5];
		end
	end

	// field unpacking, wires only
	assign txSelect            = fld_q[58];
	assign synthPowerdown      = fld_q[57];
	assign fastLockSelect      = fld_q[56];
	assign bandChoice          = fld_q[55];
	assign programmableCount   = fld_q[54:51];
	assign swallowCount        = fld_q[50:48];
	assign fractionNumerator   = fld_q[47:38];
	assign fractionDenominator = fld_q[37:28];
	assign integerDivide       = fld_q[27:20];
	assign refDivideTwo        = fld_q[19];
	assign refclkChoice        = ssprg_ref_t'(fld_q[18:17]);
	assign outBufferLevel      = fld_q[16:15];
	assign lockOut             = lock_q;
	assign setupWord2          = w2_q;
	assign setupWord3          = w3_q;
	assign setupWord4          = w4_q;
	assign setupWord5          = w5_q;
endmodule : ssprg_regs

//--- ssprg_regs_monitor.sv
// concurrent checks on the programming bank ports
`timescale 1ns/1ps
module ssprg_regs_monitor
(
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  latchStrobe,
	input wire logic                  pllLocked,
	input wire logic                  synthPowerdown,
	input wire logic                  lockOut,
	input wire logic                  txSelect,
	input wire logic                  bandChoice,
	input wire logic [3:0]            programmableCount,
	input wire logic [2:0]            swallowCount,
	input wire logic [7:0]            integerDivide,
	input wire logic [9:0]            fractionDenominator,
	input wire ssprg_pkg::ssprg_ref_t refclkChoice,
	input wire logic                  refDivideTwo,
	input wire ssprg_pkg::ssprg_word_t setupWord2,
	input wire ssprg_pkg::ssprg_word_t setupWord3
);
	import ssprg_pkg::*;
	// ****************************************
	// helper counters
	// ****************************************
	// denominators indexed by tx, band, reference
	localparam logic [9:0] DEN [16] = '{10'd504, 10'd576, 10'd504, 10'd520, 10'd504, 10'd576, 10'd504, 10'd520,
		10'd630, 10'd720, 10'd630, 10'd650, 10'd567, 10'd648, 10'd567, 10'd585};
	logic [3:0] age_q;    // clocks since latch was last high
	logic [3:0] age_d;
	logic [1:0] warm_q;   // clocks since reset, saturating
	logic [1:0] warm_d;
	// next values, saturating so old latches never wrap back
	always_comb
	begin
		age_d  = latchStrobe ? 4'h0 : ((age_q == 4'hf) ? age_q : age_q + 4'h1);
		warm_d = (warm_q == 2'h3) ? warm_q : warm_q + 2'h1;
	end
	// registers only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			age_q  <= 4'h0;
			warm_q <= 2'h0;
		end
		else
		begin
			age_q  <= age_d;
			warm_q <= warm_d;
		end
	end
	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_fields_quiet: assert property (
		$changed({txSelect, bandChoice, programmableCount, swallowCount, integerDivide, refDivideTwo})
		|-> age_q < 4'hc) else $error("field moved without a latch");
	a_words_quiet: assert property (
		$changed({setupWord2, setupWord3}) |-> age_q < 4'hc) else $error("word moved without a latch");
	a_int_upper: assert property (
		$stable({bandChoice, programmableCount, swallowCount}) && bandChoice && warm_q == 2'h3
		|-> integerDivide == {1'b0, programmableCount, 3'h0} + {5'h0, swallowCount}) else $error("upper divide");
	a_int_lower: assert property (
		$stable({bandChoice, programmableCount, swallowCount}) && !bandChoice && warm_q == 2'h3
		|-> integerDivide == {2'h0, programmableCount, 2'h0} + {5'h0, swallowCount}) else $error("lower divide");
	a_den_table: assert property (
		$stable({txSelect, bandChoice, refclkChoice}) && warm_q == 2'h3
		|-> fractionDenominator == DEN[{txSelect, bandChoice, refclkChoice}]) else $error("denominator");
	a_ref_divide: assert property (
		$stable(refclkChoice) && warm_q == 2'h3
		|-> refDivideTwo == (refclkChoice == SSPRG_REF_25M2 || refclkChoice == SSPRG_REF_26M0))
		else $error("reference divider");
	a_lock_powerdown: assert property (
		synthPowerdown && $past(synthPowerdown) |-> !lockOut) else $error("lock shown in power down");
	a_lock_follows: assert property (
		!pllLocked [*8] |-> !lockOut) else $error("lock shown while unlocked");
	c_latch: cover property ($rose(latchStrobe));
	c_lock: cover property ($rose(lockOut));
	c_tx_upper: cover property (txSelect && bandChoice);
endmodule : ssprg_regs_monitor

bind ssprg_regs ssprg_regs_monitor u_mon
(
	.clk(clk), .rst(rst), .latchStrobe(latchStrobe), .pllLocked(pllLocked),
	.synthPowerdown(synthPowerdown), .lockOut(lockOut), .txSelect(txSelect), .bandChoice(bandChoice),
	.programmableCount(programmableCount), .swallowCount(swallowCount), .integerDivide(integerDivide),
	.fractionDenominator(fractionDenominator), .refclkChoice(refclkChoice), .refDivideTwo(refDivideTwo),
	.setupWord2(setupWord2), .setupWord3(setupWord3)
);

//--- ssprg_host_model.sv
// host controller model for the three-wire programming link
`timescale 1ns/1ps
module ssprg_host_model
(
	input  wire logic clk,
	output logic      sClk,
	output logic      sData,
	output logic      latch
);
	// all lines start low; clock and latch idle low between frames
	initial
	begin
		sClk = 1'b0;
		sData = 1'b0;
		latch = 1'b0;
	end
	// one word msb first, then an optional latch pulse
	task automatic send(input logic [23:0] w, input logic go);
		for (int i = 23; i >= 0; i--)
		begin
			// bit settles four clocks before the rise
			sData <= w[i];
			repeat (4) @(posedge clk);
			sClk <= 1'b1;
			repeat (4) @(posedge clk);
			sClk <= 1'b0;
		end
		// released line shows the inverse, not a stale bit
		sData <= ~w[0];
		repeat (4) @(posedge clk);
		// latch rise well after the last clock rise
		latch <= go;
		repeat (4) @(posedge clk);
		latch <= 1'b0;
		repeat (12) @(posedge clk);
	endtask : send
endmodule : ssprg_host_model

//--- tb_top.sv
// self-checking bench for the serial programming bank
`timescale 1ns/1ps
module tb_top;
	import ssprg_pkg::*;
	// ****************************************
	// signals and instances
	// ****************************************
	localparam logic [9:0] DEN [16] = '{10'd504, 10'd576, 10'd504, 10'd520, 10'd504, 10'd576, 10'd504, 10'd520,
		10'd630, 10'd720, 10'd630, 10'd650, 10'd567, 10'd648, 10'd567, 10'd585};
	logic        clk, rst, pllLocked, sClk, sData, latch;
	logic        tx, pd, fl, bc, rd, lo;
	logic [3:0]  pc;
	logic [2:0]  sw;
	logic [9:0]  fn, fd;
	logic [7:0]  idv;
	logic [1:0]  ob;
	ssprg_ref_t  rc;
	ssprg_word_t w2, w3, w4, w5;
	int          miscompares, n_tests;
	ssprg_host_model host (.clk(clk), .sClk(sClk), .sData(sData), .latch(latch));
	ssprg_regs dut (.clk(clk), .rst(rst), .serialClk(sClk), .serialData(sData), .latchStrobe(latch),
		.pllLocked(pllLocked), .txSelect(tx), .synthPowerdown(pd), .fastLockSelect(fl), .bandChoice(bc),
		.programmableCount(pc), .swallowCount(sw), .fractionNumerator(fn), .fractionDenominator(fd),
		.integerDivide(idv), .refDivideTwo(rd), .refclkChoice(rc), .outBufferLevel(ob), .lockOut(lo),
		.setupWord2(w2), .setupWord3(w3), .setupWord4(w4), .setupWord5(w5));
	// free-running system clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// configuration word: fixed pattern plus option fields
	function automatic logic [23:0] cw(logic d, logic l, logic [1:0] o, logic [1:0] r);
		return 24'h128101 | {d, 16'h0, l, o, r, 2'b00};
	endfunction : cw
	// frequency word, bit 20 kept zero
	function automatic logic [23:0] fw(logic t, logic p, logic f, logic b, logic [3:0] c, logic [2:0] s, logic [9:0] n);
		return {t, p, f, 1'b0, b, c, s, n, 2'b00};
	endfunction : fw
	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	// ****************************************
	// scenarios
	// ****************************************
	// power-up order, upper band at the count limits
	task automatic t_init;
		host.send(24'hc87806, 1'b1);
		host.send(cw(1'b0, 1'b0, 2'b10, 2'b11), 1'b1);
		host.send(fw(1'b1, 1'b0, 1'b0, 1'b1, 4'hf, 3'h7, 10'd584), 1'b1);
		chk(w2, 24'hc87806);
		chk(24'({ob, rc}), 24'h00000b);
		chk(24'({tx, pd, fl, bc, pc, sw, fn}), 24'({4'b1001, 4'hf, 3'h7, 10'd584}));
		$display("test init done");
	endtask : t_init
	// the fixed setup words land in their own places
	task automatic t_fixed;
		host.send(24'h86801b, 1'b1);
		host.send(24'h03a327, 1'b1);
		host.send(24'h00000f, 1'b1);
		chk(w3, 24'h86801b);
		chk(w4, 24'h03a327);
		chk(w5, 24'h00000f);
		$display("test fixed done");
	endtask : t_fixed
	// every tx, band and reference combination
	task automatic t_table;
		logic [3:0] k;
		logic [2:0] s;
		logic [7:0] e;
		for (int i = 0; i < 16; i++)
		begin
			k = 4'(i);
			s = k[2] ? 3'h7 : 3'h3;
			e = (k[2] ? {1'b0, k, 3'h0} : {2'h0, k, 2'h0}) + {5'h0, s};
			host.send(cw(1'b0, 1'b0, 2'b00, k[1:0]), 1'b1);
			host.send(fw(k[3], 1'b0, 1'b0, k[2], k, s, 10'd1), 1'b1);
			chk(24'({fd, rc, rd}), 24'({DEN[i], k[1:0], k[1]}));
			chk(24'({tx, bc, idv}), 24'({k[3:2], e}));
		end
		$display("test table done");
	endtask : t_table
	// shifting alone leaves the outputs untouched
	task automatic t_shift;
		host.send(fw(1'b0, 1'b0, 1'b0, 1'b0, 4'h2, 3'h1, 10'd0), 1'b0);
		chk(24'({tx, bc, idv}), 24'({2'b11, 8'h7f}));
		$display("test shift done");
	endtask : t_shift
	// built-in words replace the first three
	task automatic t_default;
		host.send(cw(1'b1, 1'b0, 2'b11, 2'b11), 1'b1);
		chk(24'({fd, tx, bc, idv, ob, rc}), {10'd504, 14'h0});
		chk(w2, 24'hc87806);
		host.send(cw(1'b0, 1'b0, 2'b01, 2'b11), 1'b1);
		$display("test default done");
	endtask : t_default
	// lock output gating by enable and power down
	task automatic t_lock;
		host.send(cw(1'b0, 1'b1, 2'b01, 2'b11), 1'b1);
		host.send(fw(1'b0, 1'b0, 1'b1, 1'b0, 4'h2, 3'h3, 10'd519), 1'b1);
		pllLocked <= 1'b1;
		repeat (20) @(posedge clk);
		chk(24'({lo, fl, fn, ob}), 24'({2'b11, 10'd519, 2'b01}));
		host.send(fw(1'b0, 1'b1, 1'b0, 1'b0, 4'h2, 3'h3, 10'd519), 1'b1);
		chk(24'({lo, pd, fl}), 24'h2);
		host.send(cw(1'b0, 1'b0, 2'b01, 2'b11), 1'b1);
		host.send(fw(1'b0, 1'b0, 1'b0, 1'b0, 4'h2, 3'h3, 10'd519), 1'b1);
		chk(24'({lo, pd}), 24'h0);
		pllLocked <= 1'b0;
		$display("test lock done");
	endtask : t_lock
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial
	begin
		rst = 1'b1;
		pllLocked = 1'b0;
		miscompares = 0;
		n_tests = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_init;
		t_fixed;
		t_table;
		t_shift;
		t_default;
		t_lock;
		results;
	end
	// about three times the expected run length
	initial
	begin
		repeat (30000) @(posedge clk);
		miscompares++;
		results;
	end
endmodule : tb_top
